/* rtl/adc_ctrl_pkg.sv */
// constants and types of the converter rate, reset and power-down control
package adc_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int         ADR_W           = 8;
  localparam int         DAT_W           = 32;
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] LEFT_OFS        = 8'h08;
  localparam logic [7:0] RIGHT_OFS       = 8'h0C;
  localparam int         CTRL_FORCE_BIT  = 0;
  localparam int         CTRL_BYPASS_BIT = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h0;
  localparam int         ST_STATE_LSB    = 0;
  localparam int         ST_VALID_BIT    = 5;
  localparam int         ST_PDOWN_BIT    = 6;
  localparam int         ST_ERR_BIT      = 7;
  localparam int         ST_RATE_LSB     = 8;
  localparam int         ST_RATIO_LSB    = 16;

  ////////////////////////////////////////////////////////////////////////////
  // widths and timing counts
  localparam int          SAMPLE_W       = 24;
  localparam int          RATIO_W        = 10;
  localparam int          PD_W           = 17;
  localparam int          SETTLE_W       = 11;
  localparam int          ACC_W          = 8;
  localparam int          HPF_SHIFT      = 10;
  localparam logic [16:0] PDOWN_SAMPLES  = 17'h10000;
  localparam logic [10:0] SETTLE_SAMPLES = 11'h45C;
  localparam logic [4:0]  SCALE_BASE     = 5'h10;
  localparam logic [2:0]  OVER_BASE      = 3'h7;
  localparam logic [7:0]  OVER_SINGLE    = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // clock ratios and rates
  localparam logic [9:0] RATIO_128   = 10'h080;
  localparam logic [9:0] RATIO_192   = 10'h0C0;
  localparam logic [9:0] RATIO_256   = 10'h100;
  localparam logic [9:0] RATIO_384   = 10'h180;
  localparam logic [9:0] RATIO_512   = 10'h200;
  localparam logic [9:0] RATIO_768   = 10'h300;
  localparam logic [1:0] RATE_SINGLE = 2'h0;
  localparam logic [1:0] RATE_DUAL   = 2'h1;
  localparam logic [1:0] RATE_QUAD   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_HOLD   = 5'h02,
    ST_SETTLE = 5'h04,
    ST_RUN    = 5'h08,
    ST_PDOWN  = 5'h10
  } seq_state_t;

  typedef struct packed {
    logic       slave;
    logic       one_bit;
    logic [2:0] rate_sel;
  } pin_cfg_t;

  typedef struct packed {
    logic       err;
    logic [1:0] rate;
    logic [9:0] ratio;
  } mode_t;

endpackage

/* rtl/adc_rate_reset_ctrl.sv */
// rate decode, reset sequencing, power-down and decimation control of the converter
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_rate_reset_ctrl
#(
  parameter logic [adc_ctrl_pkg::PD_W-1:0]     PDOWN_SAMPLES_P  = adc_ctrl_pkg::PDOWN_SAMPLES,
  parameter logic [adc_ctrl_pkg::SETTLE_W-1:0] SETTLE_SAMPLES_P = adc_ctrl_pkg::SETTLE_SAMPLES
)
(
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  // wishbone slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [adc_ctrl_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [adc_ctrl_pkg::DAT_W-1:0]   wb_dat_i,
  output logic [adc_ctrl_pkg::DAT_W-1:0]        wb_dat_o,
  output logic                                  wb_ack_o,
  // configuration and reset pins
  input  wire logic                             reset_n_i,
  input  wire logic                             power_good_i,
  input  wire logic                             slave_mode_i,
  input  wire logic                             one_bit_stream_mode_i,
  input  wire logic                             rate_select_msb_i,
  input  wire logic                             rate_select_mid_i,
  input  wire logic                             rate_select_lsb_i,
  input  wire logic                             word_select_clock_i,
  // modulator side
  input  wire logic                             mod_left_i,
  input  wire logic                             mod_right_i,
  output logic                                  mod_tick_o,
  // audio side
  output logic [adc_ctrl_pkg::SAMPLE_W-1:0]     sample_left_o,
  output logic [adc_ctrl_pkg::SAMPLE_W-1:0]     sample_right_o,
  output logic                                  sample_valid_o,
  output logic                                  stream_left_out_o,
  output logic                                  stream_right_out_o,
  // status
  output logic                                  output_valid_o,
  output logic                                  power_down_o,
  output logic                                  config_error_o
);
  import adc_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // rate decoding
  function automatic logic legal_ratio(input logic [RATIO_W-1:0] r);
    legal_ratio = (r == RATIO_128) || (r == RATIO_256) || (r == RATIO_384) ||
                  (r == RATIO_512) || (r == RATIO_768);
  endfunction

  function automatic mode_t decode_mode(input pin_cfg_t c, input logic [RATIO_W-1:0] det);
    mode_t m;
    m = '0;
    if (!c.slave)
    begin
      // master table
      m.rate = c.rate_sel[2] ? (c.rate_sel[1] ? RATE_QUAD : RATE_DUAL) : RATE_SINGLE;
      case (c.rate_sel)
        3'h0:    m.ratio = RATIO_768;
        3'h1:    m.ratio = RATIO_512;
        3'h2:    m.ratio = RATIO_384;
        3'h3:    m.ratio = RATIO_256;
        3'h4:    m.ratio = RATIO_384;
        3'h5:    m.ratio = RATIO_256;
        3'h6:    m.ratio = RATIO_192;
        default: m.ratio = RATIO_128;
      endcase
      if (c.one_bit)
      begin
        m.rate = RATE_DUAL;
        m.err  = (c.rate_sel != 3'h4) && (c.rate_sel != 3'h5);
      end
    end
    else
    begin
      // slave table, ratio from measurement
      m.ratio = det;
      case (c.rate_sel)
        3'h0:    m.rate = RATE_SINGLE;
        3'h1:    m.rate = RATE_DUAL;
        3'h2:    m.rate = RATE_QUAD;
        default: m.err  = 1'b1;
      endcase
      if (!legal_ratio(det))
        m.err = 1'b1;
      if (m.rate == RATE_QUAD && det != RATIO_128)
        m.err = 1'b1;
      if (c.one_bit)
        m.err = 1'b1;
    end
    decode_mode = m;
  endfunction

  pin_cfg_t           cfg;
  mode_t              mode;
  logic [RATIO_W-1:0] det_ratio;
  logic               det_valid, fs_tick, mod_tick;
  logic [2:0]         over_shift;

  always_comb
  begin
    cfg        = '{slave: slave_mode_i, one_bit: one_bit_stream_mode_i,
                   rate_sel: {rate_select_msb_i, rate_select_mid_i, rate_select_lsb_i}};
    mode       = decode_mode(cfg, det_ratio);
    over_shift = OVER_BASE - {1'b0, mode.rate};
  end

  fs_timebase fs_timebase_inst
  (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .slave_i             (slave_mode_i),
    .word_select_clock_i (word_select_clock_i),
    .master_ratio_i      (slave_mode_i ? 10'h000 : mode.ratio),
    .over_shift_i        (over_shift),
    .fs_tick_o           (fs_tick),
    .mod_tick_o          (mod_tick),
    .ratio_o             (det_ratio),
    .ratio_valid_o       (det_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone registers
  logic [1:0]       ctrl_q, ctrl_d;
  logic             ack_q, ack_d;
  logic [DAT_W-1:0] rdat_q, rdat_d;
  logic             bus_req;
  seq_state_t       state_q, state_d;
  logic [SAMPLE_W-1:0] left_q, right_q;

  always_comb
  begin
    bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    ack_d   = bus_req;
    ctrl_d  = ctrl_q;
    rdat_d  = rdat_q;
    if (bus_req && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0])
      ctrl_d = wb_dat_i[1:0];
    if (bus_req)
    begin
      case (wb_adr_i)
        CTRL_OFS:   rdat_d = {30'h0, ctrl_q};
        STATUS_OFS:
        begin
          rdat_d = '0;
          rdat_d[ST_STATE_LSB +: 5]        = state_q;
          rdat_d[ST_VALID_BIT]             = output_valid_o;
          rdat_d[ST_PDOWN_BIT]             = power_down_o;
          rdat_d[ST_ERR_BIT]               = config_error_o;
          rdat_d[ST_RATE_LSB +: 2]         = mode.rate;
          rdat_d[ST_RATIO_LSB +: RATIO_W]  = mode.ratio;
        end
        LEFT_OFS:   rdat_d = {8'h00, left_q};
        RIGHT_OFS:  rdat_d = {8'h00, right_q};
        default:    rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset and power-down sequencer
  logic [PD_W-1:0]     pd_q, pd_d;
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic                hold_req, pin_low, cfg_bad, running;

  always_comb
  begin
    pin_low  = ~reset_n_i;
    cfg_bad  = mode.err | (slave_mode_i & ~det_valid);
    hold_req = pin_low | ~power_good_i | ctrl_q[CTRL_FORCE_BIT] | cfg_bad;
    state_d  = state_q;
    pd_d     = pd_q;
    settle_d = settle_q;
    case (state_q)
      ST_RESET:
      begin
        settle_d = '0;
        if (pin_low && power_good_i && fs_tick)
        begin
          // more than the limit of sample periods low
          if (pd_q == PDOWN_SAMPLES_P)
            state_d = ST_PDOWN;
          else
            pd_d = pd_q + 17'h00001;
        end
        else if (!pin_low)
          pd_d = '0;
        if (!hold_req)
          state_d = ST_HOLD;
      end
      ST_HOLD:
      begin
        pd_d = '0;
        if (hold_req)
          state_d = ST_RESET;
        else if (fs_tick)
          state_d = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (hold_req)
          state_d = ST_RESET;
        else if (fs_tick)
        begin
          settle_d = settle_q + 11'h001;
          if (settle_q == SETTLE_SAMPLES_P - 11'h001)
            state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (hold_req)
          state_d = ST_RESET;
      end
      ST_PDOWN:
      begin
        pd_d     = '0;
        settle_d = '0;
        if (!pin_low || !power_good_i)
          state_d = hold_req ? ST_RESET : ST_HOLD;
      end
      default:
        state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_RESET;
      pd_q     <= '0;
      settle_q <= '0;
    end
    else
    begin
      state_q  <= state_d;
      pd_q     <= pd_d;
      settle_q <= settle_d;
    end
  end

  assign running        = (state_q == ST_RUN);
  assign output_valid_o = running;
  assign power_down_o   = (state_q == ST_PDOWN);
  assign config_error_o = mode.err;
  assign mod_tick_o     = mod_tick;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel decimation, dc removal and one-bit path
  logic [1:0]                       mod_bit;
  logic [1:0][SAMPLE_W-1:0]         smp_q;
  logic [1:0]                       strm_q;
  logic                             svalid_q, svalid_d;
  logic [7:0]                       nominal;
  logic [4:0]                       scale;

  assign mod_bit = {mod_right_i, mod_left_i};

  always_comb
  begin
    nominal  = OVER_SINGLE >> mode.rate;
    scale    = SCALE_BASE + {3'h0, mode.rate};
    svalid_d = fs_tick & running & ~cfg.one_bit;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [ACC_W-1:0]           acc_q, acc_d;
      logic signed [SAMPLE_W-1:0] dc_q, dc_d, hp, sat;
      logic signed [24:0]         wide;
      logic [SAMPLE_W-1:0]        smp_d;
      logic                       strm_d;

      always_comb
      begin
        // count of ones over the period
        acc_d = acc_q;
        if (fs_tick)
          acc_d = {7'h00, mod_tick & mod_bit[ch]};
        else if (mod_tick)
          acc_d = acc_q + {7'h00, mod_bit[ch]};
        wide = ($signed({16'h0000, acc_q, 1'b0}) - $signed({17'h00000, nominal})) <<< scale;
        if (wide > $signed(25'h07FFFFF))
          sat = 24'h7FFFFF;
        else
          sat = wide[SAMPLE_W-1:0];
        hp    = sat - dc_q;
        dc_d  = dc_q;
        smp_d = smp_q[ch];
        if (!running || cfg.one_bit)
        begin
          dc_d  = '0;
          smp_d = '0;
        end
        else if (fs_tick)
        begin
          dc_d  = dc_q + (hp >>> HPF_SHIFT);
          smp_d = ctrl_q[CTRL_BYPASS_BIT] ? sat : hp;
        end
        // raw modulator bit straight out
        strm_d = strm_q[ch];
        if (!running || !cfg.one_bit)
          strm_d = 1'b0;
        else if (mod_tick)
          strm_d = mod_bit[ch];
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          acc_q      <= '0;
          dc_q       <= '0;
          smp_q[ch]  <= '0;
          strm_q[ch] <= 1'b0;
        end
        else
        begin
          acc_q      <= acc_d;
          dc_q       <= dc_d;
          smp_q[ch]  <= smp_d;
          strm_q[ch] <= strm_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      svalid_q <= 1'b0;
    else
      svalid_q <= svalid_d;
  end

  assign left_q             = smp_q[0];
  assign right_q            = smp_q[1];
  assign sample_left_o      = smp_q[0];
  assign sample_right_o     = smp_q[1];
  assign sample_valid_o     = svalid_q;
  assign stream_left_out_o  = strm_q[0];
  assign stream_right_out_o = strm_q[1];

endmodule
`default_nettype wire

/* rtl/fs_timebase.sv */
// sample-period and modulator tick generation with word clock ratio measurement
`timescale 1ns/1ps
`default_nettype none
module fs_timebase
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // configuration
  input  wire logic                        slave_i,
  input  wire logic                        word_select_clock_i,
  input  wire logic [adc_ctrl_pkg::RATIO_W-1:0] master_ratio_i,
  input  wire logic [2:0]                  over_shift_i,
  // timing
  output logic                             fs_tick_o,
  output logic                             mod_tick_o,
  output logic [adc_ctrl_pkg::RATIO_W-1:0] ratio_o,
  output logic                             ratio_valid_o
);
  import adc_ctrl_pkg::*;

  logic               wclk_q, wclk_d;
  logic [RATIO_W-1:0] per_q, per_d, ratio_q, ratio_d, mod_q, mod_d, div;
  logic               seen_q, seen_d, valid_q, valid_d;
  logic               fs_q, fs_d, modt_q, modt_d, rise, per_end, mod_end;

  ////////////////////////////////////////////////////////////////////////////
  // period counter and ratio measurement
  always_comb
  begin
    rise    = word_select_clock_i & ~wclk_q;
    per_end = (per_q == master_ratio_i - 10'h001);
    wclk_d  = word_select_clock_i;
    per_d   = per_q;
    ratio_d = ratio_q;
    seen_d  = seen_q;
    valid_d = valid_q;
    fs_d    = 1'b0;
    if (slave_i)
    begin
      // rising word clock edges pace the sample period
      fs_d = rise;
      if (rise)
      begin
        per_d   = 10'h001;
        ratio_d = per_q;
        seen_d  = 1'b1;
        valid_d = seen_q;
      end
      else if (per_q != 10'h3FF)
        per_d = per_q + 10'h001;
      else
        valid_d = 1'b0;
    end
    else
    begin
      fs_d    = per_end;
      per_d   = per_end ? 10'h000 : per_q + 10'h001;
      seen_d  = 1'b0;
      valid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulator tick, restarted at each sample period
  always_comb
  begin
    div     = (slave_i ? ratio_q : master_ratio_i) >> over_shift_i;
    mod_end = (div > 10'h001) && (mod_q == div - 10'h001);
    modt_d  = mod_end;
    mod_d   = (fs_d || mod_end) ? 10'h000 : mod_q + 10'h001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wclk_q  <= 1'b0;
      per_q   <= 10'h000;
      ratio_q <= 10'h000;
      seen_q  <= 1'b0;
      valid_q <= 1'b0;
      fs_q    <= 1'b0;
      mod_q   <= 10'h000;
      modt_q  <= 1'b0;
    end
    else
    begin
      wclk_q  <= wclk_d;
      per_q   <= per_d;
      ratio_q <= ratio_d;
      seen_q  <= seen_d;
      valid_q <= valid_d;
      fs_q    <= fs_d;
      mod_q   <= mod_d;
      modt_q  <= modt_d;
    end
  end

  assign fs_tick_o     = fs_q;
  assign mod_tick_o    = modt_q;
  assign ratio_o       = ratio_q;
  assign ratio_valid_o = valid_q;

endmodule
`default_nettype wire

/* testbench/adc_ctrl_props.sv */
// assertion checker of the rate, reset and power-down control
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props
(
  // clock, reset and bus
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  input wire logic                              wb_cyc_i,
  input wire logic                              wb_stb_i,
  input wire logic                              wb_ack_o,
  // pins
  input wire logic                              reset_n_i,
  input wire logic                              power_good_i,
  input wire logic                              one_bit_stream_mode_i,
  // outputs
  input wire logic                              mod_tick_o,
  input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] sample_left_o,
  input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] sample_right_o,
  input wire logic                              sample_valid_o,
  input wire logic                              stream_left_out_o,
  input wire logic                              stream_right_out_o,
  input wire logic                              output_valid_o,
  input wire logic                              power_down_o,
  input wire logic                              config_error_o
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since pin and power both released
  logic [11:0] up_q;
  logic [11:0] up_d;
  always_comb
  begin
    up_d = up_q + {11'h0, !(&up_q)};
    if (!(reset_n_i && power_good_i))
      up_d = 12'h0;
  end
  always_ff @(posedge clk_i)
  begin
    up_q <= rst_i ? 12'h0 : up_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pin_hold_a: assert property (!reset_n_i |=> !output_valid_o)
    else $error("running with reset pin low");
  pgood_hold_a: assert property (!power_good_i |=> !output_valid_o && !power_down_o)
    else $error("not held by power fail");
  cfg_hold_a: assert property (config_error_o |=> !output_valid_o)
    else $error("running with bad configuration");
  zero_out_a: assert property (!output_valid_o && !$past(output_valid_o) |->
    sample_left_o == 24'h0 && sample_right_o == 24'h0) else $error("samples not zero");
  stream_zero_a: assert property (!$past(output_valid_o && one_bit_stream_mode_i) |->
    !stream_left_out_o && !stream_right_out_o) else $error("stream bits outside mode");
  sample_run_a: assert property (sample_valid_o |-> $past(output_valid_o))
    else $error("sample strobe outside run");
  pd_entry_a: assert property ($rose(power_down_o) |-> !$past(reset_n_i))
    else $error("power-down without pin low");
  pd_exit_a: assert property (power_down_o && reset_n_i |=> !power_down_o)
    else $error("power-down kept after release");
  run_time_a: assert property ($rose(output_valid_o) |-> up_q > 12'h45C)
    else $error("valid before settling");
  mod_pulse_a: assert property (mod_tick_o |=> !mod_tick_o)
    else $error("modulator tick too long");
endmodule
bind adc_rate_reset_ctrl adc_ctrl_props adc_ctrl_props_inst
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .reset_n_i, .power_good_i,
  .one_bit_stream_mode_i, .mod_tick_o, .sample_left_o, .sample_right_o, .sample_valid_o,
  .stream_left_out_o, .stream_right_out_o, .output_valid_o, .power_down_o, .config_error_o
);
`default_nettype wire

/* testbench/adc_rate_reset_ctrl_test.sv */
// self-checking bench of the rate, reset and power-down control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module adc_rate_reset_ctrl_test;
  import adc_ctrl_pkg::*;
  localparam int LIMIT = 60000;
  localparam logic [10:0] SETTLE_T = 11'h040;
  logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0]    wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [DAT_W-1:0]    wb_dat_i, wb_dat_o, rd;
  logic                reset_n_i, power_good_i, word_select_clock_i, mod_left_i, mod_right_i;
  pin_cfg_t            cfg;
  logic [9:0]          word_half;
  logic [SAMPLE_W-1:0] sample_left_o, sample_right_o;
  logic                mod_tick_o, sample_valid_o, stream_left_out_o, stream_right_out_o;
  logic                output_valid_o, power_down_o, config_error_o;
  logic [9:0]          mratio [8];
  logic [15:0]         etab [10];
  int                  n_mismatch = 0;
  int                  n_compared = 0;
  int                  cyc_n = 0;
  adc_rate_reset_ctrl #(.PDOWN_SAMPLES_P(17'h00008), .SETTLE_SAMPLES_P(SETTLE_T))
    adc_rate_reset_ctrl_inst
  (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .reset_n_i, .power_good_i,
    .slave_mode_i(cfg.slave), .one_bit_stream_mode_i(cfg.one_bit),
    .rate_select_msb_i(cfg.rate_sel[2]), .rate_select_mid_i(cfg.rate_sel[1]),
    .rate_select_lsb_i(cfg.rate_sel[0]), .word_select_clock_i, .mod_left_i, .mod_right_i,
    .mod_tick_o, .sample_left_o, .sample_right_o, .sample_valid_o, .stream_left_out_o,
    .stream_right_out_o, .output_valid_o, .power_down_o, .config_error_o
  );
  host_pins_model host_pins_model_inst
  (
    .clk_i, .rst_i, .word_half_i(word_half), .word_select_clock_o(word_select_clock_i),
    .mod_left_o(mod_left_i), .mod_right_o(mod_right_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk_i = ~clk_i;
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // pins change only while the reset pin is low
  task automatic set_pins(input logic sl, input logic ob, input logic [2:0] code,
                          input logic [9:0] half);
    reset_n_i <= 1'h0;
    @(posedge clk_i);
    cfg <= '{sl, ob, code};
    word_half <= half;
    tick(6 * half + 8);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    reset_n_i = 1'h0;
    power_good_i = 1'h1;
    cfg = '{1'h0, 1'h0, 3'h0};
    word_half = 10'h080;
    mratio = '{RATIO_768, RATIO_512, RATIO_384, RATIO_256, RATIO_384, RATIO_256,
               RATIO_192, RATIO_128};
    etab = '{{1'h1, 1'h0, 3'h1, 10'h0C0, 1'h0}, {1'h1, 1'h0, 3'h0, 10'h100, 1'h0},
             {1'h1, 1'h0, 3'h0, 10'h180, 1'h0}, {1'h1, 1'h0, 3'h2, 10'h080, 1'h1},
             {1'h1, 1'h0, 3'h2, 10'h040, 1'h0}, {1'h1, 1'h0, 3'h0, 10'h060, 1'h1},
             {1'h0, 1'h1, 3'h4, 10'h080, 1'h0}, {1'h0, 1'h1, 3'h5, 10'h080, 1'h0},
             {1'h0, 1'h1, 3'h0, 10'h080, 1'h1}, {1'h1, 1'h1, 3'h1, 10'h080, 1'h1}};
    tick(5);
    rst_i <= 1'h0;
    tick(4);
    wb_xfer(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[4:0], ST_RESET);
    wb_xfer(1'h1, CTRL_OFS, 32'hFFFFFFFF);
    wb_xfer(1'h0, CTRL_OFS, 32'h0);
    `CHK(rd, 32'h3);
    wb_xfer(1'h1, CTRL_OFS, 32'h0);
    wb_xfer(1'h1, 8'h10, 32'hFFFFFFFF);
    wb_xfer(1'h0, 8'h10, 32'h0);
    `CHK(rd, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      set_pins(1'h0, 1'h0, 3'(c), 10'h008);
      wb_xfer(1'h0, STATUS_OFS, 32'h0);
      `CHK(rd[25:16], mratio[c]);
      `CHK(rd[9:8], (c < 4) ? RATE_SINGLE : ((c < 6) ? RATE_DUAL : RATE_QUAD));
      `CHK(config_error_o, 1'h0);
    end
    set_pins(1'h1, 1'h0, 3'h0, 10'h080);
    wb_xfer(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[25:16], RATIO_256);
    `CHK(rd[9:8], RATE_SINGLE);
    for (int c = 3; c < 8; c++)
    begin
      set_pins(1'h1, 1'h0, 3'(c), 10'h080);
      `CHK(config_error_o, 1'h1);
    end
    foreach (etab[i])
    begin
      set_pins(etab[i][15], etab[i][14], etab[i][13:11], etab[i][10:1]);
      `CHK(config_error_o, etab[i][0]);
    end
    set_pins(1'h0, 1'h0, 3'h7, 10'h008);
    reset_n_i <= 1'h1;
    tick(4);
    reset_n_i <= 1'h0;
    tick(7 * 128);
    `CHK(power_down_o, 1'h0);
    tick(3 * 128);
    `CHK(power_down_o, 1'h1);
    reset_n_i <= 1'h1;
    tick(2);
    `CHK(power_down_o, 1'h0);
    tick(SETTLE_T * 128 - 200);
    `CHK(output_valid_o, 1'h0);
    for (int i = 0; i < 700 && output_valid_o !== 1'h1; i++)
      @(posedge clk_i);
    `CHK(output_valid_o, 1'h1);
    for (int i = 0; i < 300 && sample_valid_o !== 1'h1; i++)
      @(posedge clk_i);
    `CHK(sample_valid_o, 1'h1);
    `CHK(stream_left_out_o, 1'h0);
    wb_xfer(1'h1, CTRL_OFS, 32'h1);
    tick(1);
    `CHK(output_valid_o, 1'h0);
    tick(2);
    `CHK(sample_left_o | sample_right_o, 24'h0);
    wb_xfer(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[4:0], ST_RESET);
    wb_xfer(1'h1, CTRL_OFS, 32'h0);
    set_pins(1'h0, 1'h1, 3'h5, 10'h008);
    reset_n_i <= 1'h1;
    for (int i = 0; i < SETTLE_T * 256 + 600 && stream_right_out_o !== 1'h1; i++)
      @(posedge clk_i);
    `CHK({stream_right_out_o, sample_valid_o, output_valid_o}, 3'h5);
    wb_xfer(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[9:8], RATE_DUAL);
    power_good_i <= 1'h0;
    tick(3);
    wb_xfer(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[6:0], {2'h0, ST_RESET});
    give_verdict();
  end
endmodule
`default_nettype wire

/* testbench/host_pins_model.sv */
// host-side model driving word clock and modulator bits
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // word clock half period in system clocks
  input  wire logic [9:0] word_half_i,
  // pins
  output logic            word_select_clock_o,
  output logic            mod_left_o,
  output logic            mod_right_o
);
  logic [9:0] cnt_q;
  logic [4:0] pat_q;
  initial
  begin
    cnt_q = 10'h0;
    pat_q = 5'h0;
    word_select_clock_o = 1'h0;
    mod_left_o = 1'h0;
    mod_right_o = 1'h1;
  end
  // clocks keep running through reset and power-down
  always @(posedge clk_i)
  begin
    cnt_q <= (cnt_q >= word_half_i - 10'h1) ? 10'h0 : cnt_q + 10'h1;
    if (cnt_q >= word_half_i - 10'h1)
      word_select_clock_o <= !word_select_clock_o;
    pat_q <= rst_i ? 5'h0 : pat_q + 5'h1;
    mod_left_o <= pat_q[2];
    mod_right_o <= !pat_q[4];
  end
endmodule
`default_nettype wire
